// ==== rtl/smf_cong_chan.sv ====
// Per-channel congestion timer driving the XOFF request
// Assumes congestion input is synchronous to i_clk_sys
`timescale 1ns/1ps
module smf_cong_chan #(
  parameter int unsigned LIMIT_CYC = smf_pkg::CONG_LIMIT_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_gen_en,
  input  wire logic i_cong,
  output logic      o_xoff_req,
  output logic      o_init
);
  import smf_pkg::*;

  smf_cong_t   state_q;
  logic [31:0] cnt_q;
  logic        armed_q;
  logic        cnt_end;
  logic [31:0] xoff_run_q;

  assign cnt_end = (cnt_q == LIMIT_CYC - 1);
  assign o_xoff_req = (state_q == CG_XOFF);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= CG_IDLE;
    end else begin
      case (state_q)
        CG_IDLE: begin
          if (i_gen_en && i_cong && armed_q && !o_init) begin
            state_q <= CG_XOFF;
          end
        end
        CG_XOFF: begin
          if (!i_gen_en || !i_cong) begin
            state_q <= CG_IDLE;
          end else if (cnt_end) begin
            state_q <= CG_HOLD;
          end
        end
        CG_HOLD: begin
          if (!i_gen_en || !i_cong || cnt_end) begin
            state_q <= CG_IDLE;
          end
        end
        default: state_q <= CG_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 32'h0000_0000;
    end else if (state_q == CG_IDLE || cnt_end) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // Re-arm only once congestion clears, so a stuck channel stays quiet
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_q <= 1'b1;
      o_init <= 1'b0;
    end else begin
      o_init <= (state_q == CG_HOLD) && i_gen_en && i_cong && cnt_end;
      if (o_init) begin
        armed_q <= 1'b0;
      end else if (!i_cong) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Request run length, counted apart from the interval timer
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xoff_run_q <= 32'h0000_0000;
    end else if (o_xoff_req) begin
      xoff_run_q <= xoff_run_q + 32'h0000_0001;
    end else begin
      xoff_run_q <= 32'h0000_0000;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  property p_xoff_bound;
    o_xoff_req |-> (xoff_run_q < LIMIT_CYC);
  endproperty
  a_xoff_bound: assert property (p_xoff_bound) else $error("XOFF held past limit");

  property p_init_drop;
    o_init |-> !o_xoff_req && state_q == CG_IDLE && $past(state_q) == CG_HOLD;
  endproperty
  a_init_drop: assert property (p_init_drop) else $error("Init without withdrawal");

  c_init: cover property (o_init);
endmodule

// ==== rtl/smf_pkg.sv ====
// Constants, codes and types for the sideband multicast/flow-control block
// Assumes one 40 MHz system clock; shared by the top and the channel timer
package smf_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned MC_ENTRIES = 2;
  localparam int unsigned MAC_W = 48;
  localparam int unsigned MAC_IG_BIT = 40;

  // Command types; responses carry the same code with the top bit set
  localparam logic [7:0] CMD_GMC_EN = 8'h12;
  localparam logic [7:0] CMD_GMC_DIS = 8'h13;
  localparam logic [7:0] CMD_SET_FC = 8'h14;
  localparam logic [7:0] CMD_GET_VER = 8'h15;
  localparam logic [7:0] RSP_FLAG = 8'h80;
  localparam logic [4:0] CHAN_PKG = 5'h1F;

  // Flow control enable values
  localparam logic [7:0] FC_OFF = 8'h00;
  localparam logic [7:0] FC_GEN = 8'h01;
  localparam logic [7:0] FC_HONOR = 8'h02;
  localparam logic [7:0] FC_BOTH = 8'h03;

  // Response and reason codes
  localparam logic [15:0] RSP_COMPLETED = 16'h0000;
  localparam logic [15:0] RSP_FAILED = 16'h0001;
  localparam logic [15:0] RSP_UNSUPPORTED = 16'h0003;
  localparam logic [15:0] RSN_NONE = 16'h0000;
  localparam logic [15:0] RSN_PARAM = 16'h0002;
  localparam logic [15:0] RSN_FC_INDEP = 16'h1409;
  localparam logic [15:0] RSN_UNKNOWN = 16'h7FFF;

  // Capabilities of this build
  localparam logic CAP_MCAST_ALL = 1'b1;
  localparam logic CAP_FC_INDEP = 1'b0;

  // Packet byte layout
  localparam int unsigned HDR_LAST = 15;
  localparam int unsigned CMD_CKSUM_FIRST = 16;
  localparam int unsigned CMD_PAD_FIRST = 20;
  localparam int unsigned CMD_ARG_FIRST = 16;
  localparam int unsigned RSP_CODE_FIRST = 16;
  localparam int unsigned RSP_CKSUM_FIRST = 20;
  localparam int unsigned RSP_PAD_FIRST = 24;
  localparam int unsigned PAD_LAST = 45;

  // Congestion pause limit
  localparam int unsigned CONG_PAUSE_LIMIT_MS = 100;
  localparam int unsigned CONG_LIMIT_CYC = CONG_PAUSE_LIMIT_MS * (CLK_HZ / 1000);

  // APB register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_PKG = 12'h008;
  localparam int unsigned CTRL_MCALL_BIT = 0;
  localparam int unsigned STAT_FC_LSB = 0;
  localparam int unsigned STAT_XOFF_BIT = 2;
  localparam int unsigned STAT_PEND_BIT = 3;
  localparam int unsigned STAT_REQ_LSB = 4;
  localparam logic CTRL_MCALL_RST = 1'b0;
  localparam logic [1:0] FC_MODE_RST = 2'h0;
  localparam logic [2:0] PKG_ID_RST = 3'h0;

  typedef enum logic [1:0] {
    CG_IDLE = 2'b00,
    CG_XOFF = 2'b01,
    CG_HOLD = 2'b10
  } smf_cong_t;
endpackage

// ==== rtl/smf_top.sv ====
// Sideband command handler: global multicast filter and flow control
// Assumes an upstream parser that flags checksum and identifier errors,
// a response builder downstream, and an APB master for local registers
//
// Functional notes
// - Global accept forwards every multicast frame
// - Multicast commands exist only with accept-all
// - Otherwise multicast passes only on enabled match
// - Disable command: header, checksum, then padding
// - Disable command answered with its response type
// - Response: header, codes, checksum, padding
// - Flow control addressed to package, channel 0x1F
// - Congested channel requests XOFF one limit interval
// - Still congested after second interval: reinit
// - Package XOFF while any channel requests it
// - Flow control independent of package arbitration
// - Flow enable in low byte, upper reserved
// - Zero disables flow control; 4+ reserved
// - Values 1,2,3 select generate, honour, both
// - Valid flow control command always answered
// - Joint-only build rejects one-way request
// - Version query: header, checksum, padding
`timescale 1ns/1ps
module smf_top #(
  parameter int unsigned CONG_LIMIT_CYC = smf_pkg::CONG_LIMIT_CYC
) (
  input  wire logic                                         i_clk_sys,
  input  wire logic                                         i_reset_n,
  input  wire logic                                         i_psel,
  input  wire logic                                         i_penable,
  input  wire logic                                         i_pwrite,
  input  wire logic [11:0]                                  i_paddr,
  input  wire logic [31:0]                                  i_pwdata,
  output logic [31:0]                                       o_prdata,
  output logic                                              o_pready,
  output logic                                              o_pslverr,
  input  wire logic                                         i_cmd_valid,
  output logic                                              o_cmd_ready,
  input  wire logic [7:0]                                   i_cmd_type,
  input  wire logic [7:0]                                   i_cmd_chan_id,
  input  wire logic [31:0]                                  i_cmd_word,
  input  wire logic                                         i_cmd_err,
  output logic                                              o_rsp_valid,
  input  wire logic                                         i_rsp_ready,
  output logic [7:0]                                        o_rsp_type,
  output logic [15:0]                                       o_rsp_code,
  output logic [15:0]                                       o_rsp_reason,
  input  wire logic                                         i_frm_valid,
  input  wire logic [smf_pkg::MAC_W-1:0]                    i_frm_dst,
  input  wire logic [smf_pkg::MC_ENTRIES-1:0]               i_mcf_en,
  input  wire logic [smf_pkg::MC_ENTRIES*smf_pkg::MAC_W-1:0] i_mcf_addr,
  output logic                                              o_frm_valid,
  output logic                                              o_frm_fwd,
  input  wire logic [smf_pkg::NUM_CHAN-1:0]                 i_chan_cong,
  output logic                                              o_xoff_gen,
  output logic                                              o_pause_honor,
  output logic [smf_pkg::NUM_CHAN-1:0]                      o_chan_init
);
  import smf_pkg::*;

  logic                  mcast_all_q;
  logic [1:0]            fc_mode_q;
  logic [2:0]            pkg_id_q;
  logic                  take;
  logic                  drop;
  logic                  fc_addr_ok;
  logic [7:0]            fc_en;
  logic [15:0]           code_d;
  logic [15:0]           rsn_d;
  logic                  mc_set;
  logic                  mc_val;
  logic                  fc_set;
  logic [MC_ENTRIES-1:0] mc_hit;
  logic                  frm_is_mc;
  logic [NUM_CHAN-1:0]   chan_req;
  logic                  apb_wr;
  logic                  apb_setup;
  logic                  addr_hit;
  logic [31:0]           rdata_d;

  // Command intake; one response outstanding at a time
  assign o_cmd_ready = !o_rsp_valid;
  assign take = i_cmd_valid && o_cmd_ready;
  assign fc_addr_ok = (i_cmd_chan_id[4:0] == CHAN_PKG) && (i_cmd_chan_id[7:5] == pkg_id_q);
  // Silently dropped commands produce no response at all
  assign drop = i_cmd_err || ((i_cmd_type == CMD_SET_FC) && !fc_addr_ok);
  assign fc_en = i_cmd_word[7:0];

  always_comb begin
    code_d = RSP_COMPLETED;
    rsn_d = RSN_NONE;
    mc_set = 1'b0;
    mc_val = 1'b0;
    fc_set = 1'b0;
    case (i_cmd_type)
      CMD_GMC_EN, CMD_GMC_DIS: begin
        if (CAP_MCAST_ALL) begin
          mc_set = 1'b1;
          mc_val = (i_cmd_type == CMD_GMC_DIS);
        end else begin
          code_d = RSP_UNSUPPORTED;
          rsn_d = RSN_UNKNOWN;
        end
      end
      CMD_SET_FC: begin
        if (fc_en > FC_BOTH) begin
          code_d = RSP_FAILED;
          rsn_d = RSN_PARAM;
        end else if (!CAP_FC_INDEP && (fc_en == FC_GEN || fc_en == FC_HONOR)) begin
          code_d = RSP_FAILED;
          rsn_d = RSN_FC_INDEP;
        end else begin
          fc_set = 1'b1;
        end
      end
      CMD_GET_VER: begin
        code_d = RSP_COMPLETED;
      end
      default: begin
        code_d = RSP_UNSUPPORTED;
        rsn_d = RSN_UNKNOWN;
      end
    endcase
  end

  // Response fields held until the builder takes them
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_type <= 8'h00;
      o_rsp_code <= 16'h0000;
      o_rsp_reason <= 16'h0000;
    end else if (take && !drop) begin
      o_rsp_valid <= 1'b1;
      o_rsp_type <= i_cmd_type | RSP_FLAG;
      o_rsp_code <= code_d;
      o_rsp_reason <= rsn_d;
    end else if (o_rsp_valid && i_rsp_ready) begin
      o_rsp_valid <= 1'b0;
    end
  end

  // APB slave, zero wait states
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign addr_hit = (i_paddr == REG_CTRL) || (i_paddr == REG_STAT) || (i_paddr == REG_PKG);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_paddr)
      REG_CTRL: rdata_d[CTRL_MCALL_BIT] = mcast_all_q;
      REG_STAT: begin
        rdata_d[STAT_FC_LSB +: 2] = fc_mode_q;
        rdata_d[STAT_XOFF_BIT] = o_xoff_gen;
        rdata_d[STAT_PEND_BIT] = o_rsp_valid;
        rdata_d[STAT_REQ_LSB +: NUM_CHAN] = chan_req;
      end
      REG_PKG: rdata_d[2:0] = pkg_id_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      o_prdata <= rdata_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pkg_id_q <= PKG_ID_RST;
    end else if (apb_wr && i_paddr == REG_PKG) begin
      pkg_id_q <= i_pwdata[2:0];
    end
  end

  // A command beats a same-cycle software write
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mcast_all_q <= CTRL_MCALL_RST;
    end else if (take && !drop && mc_set) begin
      mcast_all_q <= mc_val;
    end else if (apb_wr && i_paddr == REG_CTRL) begin
      mcast_all_q <= i_pwdata[CTRL_MCALL_BIT];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fc_mode_q <= FC_MODE_RST;
    end else if (take && !drop && fc_set) begin
      fc_mode_q <= fc_en[1:0];
    end
  end

  // Multicast filter against the address table
  assign frm_is_mc = i_frm_dst[MAC_IG_BIT];

  for (genvar gi = 0; gi < MC_ENTRIES; gi++) begin : g_mcf
    assign mc_hit[gi] = i_mcf_en[gi] && (i_mcf_addr[gi*MAC_W +: MAC_W] == i_frm_dst);
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frm_valid <= 1'b0;
      o_frm_fwd <= 1'b0;
    end else begin
      o_frm_valid <= i_frm_valid;
      o_frm_fwd <= i_frm_valid && (!frm_is_mc || mcast_all_q || (|mc_hit));
    end
  end

  // Per-channel timers; no arbitration state feeds them
  for (genvar gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
    smf_cong_chan #(
      .LIMIT_CYC (CONG_LIMIT_CYC)
    ) u_cong (
      .i_clk_sys  (i_clk_sys),
      .i_reset_n  (i_reset_n),
      .i_gen_en   (fc_mode_q[0]),
      .i_cong     (i_chan_cong[gc]),
      .o_xoff_req (chan_req[gc]),
      .o_init     (o_chan_init[gc])
    );
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_xoff_gen <= 1'b0;
      o_pause_honor <= 1'b0;
    end else begin
      o_xoff_gen <= fc_mode_q[0] && (|chan_req);
      o_pause_honor <= fc_mode_q[1];
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  property p_mc_all;
    i_frm_valid && mcast_all_q |=> o_frm_valid && o_frm_fwd;
  endproperty
  a_mc_all: assert property (p_mc_all) else $error("Multicast dropped in accept-all");

  property p_mc_reject;
    i_frm_valid && frm_is_mc && !mcast_all_q && !(|mc_hit) |=> !o_frm_fwd;
  endproperty
  a_mc_reject: assert property (p_mc_reject) else $error("Unmatched multicast passed");

  property p_gmc_cap;
    take && !drop && i_cmd_type == CMD_GMC_DIS |=>
      (CAP_MCAST_ALL ? mcast_all_q : o_rsp_code == RSP_UNSUPPORTED);
  endproperty
  a_gmc_cap: assert property (p_gmc_cap) else $error("Disable-filter capability mismatch");

  property p_gmc_rsp;
    take && !drop && i_cmd_type == CMD_GMC_DIS |=>
      o_rsp_valid && o_rsp_type == 8'h93 && o_rsp_reason == RSN_NONE;
  endproperty
  a_gmc_rsp: assert property (p_gmc_rsp) else $error("Bad disable-filter response");

  property p_rsp_type;
    take && !drop |=> o_rsp_valid && o_rsp_type == ($past(i_cmd_type) | RSP_FLAG);
  endproperty
  a_rsp_type: assert property (p_rsp_type) else $error("Response type wrong");

  property p_fc_addr;
    take && !i_cmd_err && i_cmd_type == CMD_SET_FC && i_cmd_chan_id[4:0] != CHAN_PKG |=>
      !o_rsp_valid && $stable(fc_mode_q);
  endproperty
  a_fc_addr: assert property (p_fc_addr) else $error("Channel-addressed flow cmd taken");

  property p_fc_rsp;
    take && !i_cmd_err && i_cmd_type == CMD_SET_FC && fc_addr_ok |=> o_rsp_valid;
  endproperty
  a_fc_rsp: assert property (p_fc_rsp) else $error("Flow command not answered");

  property p_fc_rsvd;
    take && !drop && i_cmd_type == CMD_SET_FC && fc_en > FC_BOTH |=>
      o_rsp_code == RSP_FAILED && $stable(fc_mode_q);
  endproperty
  a_fc_rsvd: assert property (p_fc_rsvd) else $error("Reserved enable accepted");

  property p_fc_indep;
    take && !drop && i_cmd_type == CMD_SET_FC && !CAP_FC_INDEP &&
      (fc_en == FC_GEN || fc_en == FC_HONOR) |=> o_rsp_reason == RSN_FC_INDEP;
  endproperty
  a_fc_indep: assert property (p_fc_indep) else $error("One-way request not rejected");

  property p_fc_mode;
    take && !drop && i_cmd_type == CMD_SET_FC && fc_en == FC_BOTH |=> ##1 o_pause_honor && fc_mode_q == 2'h3;
  endproperty
  a_fc_mode: assert property (p_fc_mode) else $error("Both-way mode not applied");

  property p_xoff_any;
    o_xoff_gen == $past(fc_mode_q[0] && (|chan_req));
  endproperty
  a_xoff_any: assert property (p_xoff_any) else $error("Package XOFF not tracking channels");

  property p_rsp_hold;
    o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_type) && $stable(o_rsp_code);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("Response dropped before taken");

  property p_gmc_word;
    take && !drop && i_cmd_type == CMD_GMC_DIS |=> o_rsp_code == RSP_COMPLETED;
  endproperty
  a_gmc_word: assert property (p_gmc_word) else $error("Disable-filter payload not ignored");

  property p_fc_word;
    take && !drop && i_cmd_type == CMD_SET_FC && (fc_en == FC_OFF || fc_en == FC_BOTH) |=>
      fc_mode_q == $past(fc_en[1:0]);
  endproperty
  a_fc_word: assert property (p_fc_word) else $error("Flow enable byte misread");

  property p_ver_rsp;
    take && !drop && i_cmd_type == CMD_GET_VER |=>
      o_rsp_code == RSP_COMPLETED && o_rsp_reason == RSN_NONE && $stable(fc_mode_q);
  endproperty
  a_ver_rsp: assert property (p_ver_rsp) else $error("Version query mishandled");

  property p_xon_all;
    !(|chan_req) |=> !o_xoff_gen;
  endproperty
  a_xon_all: assert property (p_xon_all) else $error("XOFF kept after all withdrew");

  property p_honor_joint;
    o_pause_honor |-> $past(fc_mode_q) == 2'h3;
  endproperty
  a_honor_joint: assert property (p_honor_joint) else $error("Honour enabled alone");

  property p_frm_idle;
    !i_frm_valid |=> !o_frm_valid && !o_frm_fwd;
  endproperty
  a_frm_idle: assert property (p_frm_idle) else $error("Frame result without frame");

  c_gmc_dis: cover property (take && !drop && i_cmd_type == CMD_GMC_DIS);
  c_fc_both: cover property (take && !drop && i_cmd_type == CMD_SET_FC && fc_en == FC_BOTH);
  c_xoff: cover property (o_xoff_gen);
  c_mc_drop: cover property (o_frm_valid && !o_frm_fwd);
endmodule

// ==== tb/smf_mc_model.sv ====
// Management controller model: sends commands, collects responses
// Assumes the command and response ports of smf_top on one clock
`timescale 1ns/1ps
module smf_mc_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_cmd_ready,
  input  wire logic        i_rsp_valid,
  input  wire logic [7:0]  i_rsp_type,
  input  wire logic [15:0] i_rsp_code,
  input  wire logic [15:0] i_rsp_reason,
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd_type,
  output logic [7:0]       o_cmd_chan_id,
  output logic [31:0]      o_cmd_word,
  output logic             o_cmd_err,
  output logic             o_rsp_ready
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_type = 8'h00;
    o_cmd_chan_id = 8'h00;
    o_cmd_word = 32'h0;
    o_cmd_err = 1'b0;
    o_rsp_ready = 1'b0;
  end

  // Slow answers hold ready low for stall cycles; drops give up after 20
  task automatic xfer(input logic [7:0] t, input logic [7:0] ch, input logic [31:0] w,
                      input logic e, input int stall, output logic got, output logic [39:0] rsp);
    int n;
    got = 1'b0;
    rsp = 40'h0;
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b1;
    o_cmd_type <= t;
    o_cmd_chan_id <= ch;
    o_cmd_word <= w;
    o_cmd_err <= e;
    do begin
      @(posedge i_clk_sys);
    end while (!i_cmd_ready);
    // Released fields show the inverse, never a stale copy
    o_cmd_valid <= 1'b0;
    o_cmd_type <= ~t;
    o_cmd_chan_id <= ~ch;
    o_cmd_word <= ~w;
    o_cmd_err <= ~e;
    o_rsp_ready <= (stall == 0);
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk_sys);
      if (i_rsp_valid && o_rsp_ready) begin
        got = 1'b1;
        rsp = {i_rsp_type, i_rsp_code, i_rsp_reason};
        break;
      end
      if (n + 1 >= stall) o_rsp_ready <= 1'b1;
    end
    o_rsp_ready <= 1'b0;
  endtask
endmodule

// ==== tb/smf_top_tb.sv ====
// Self-checking bench for smf_top: commands, frames, flow control, APB
// Assumes smf_mc_model stands on the management controller side
`timescale 1ns/1ps
module smf_top_tb;
  import smf_pkg::*;
  localparam int LIM = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cv, cr, cerr, rv, rr, got, er, fv, fov, fof, xoff, honor;
  logic [7:0]  ct, cc, rt;
  logic [31:0] cw;
  logic [15:0] rc, rn;
  logic [39:0] rsp;
  logic [47:0] fdst;
  logic [1:0]  mcf_en, mode;
  logic [95:0] mcf_addr;
  logic [3:0]  cong, cinit;
  logic [7:0]  tbl [8] = '{8'h03, 8'h01, 8'h02, 8'h04, 8'hFF, 8'h00, 8'h80, 8'h03};
  int          mismatches = 0;
  int          tests_run = 0;
  int          hi, ini;

  always #12.5 clk = ~clk;

  smf_top #(.CONG_LIMIT_CYC(LIM)) smf_top_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cmd_valid(cv), .o_cmd_ready(cr), .i_cmd_type(ct), .i_cmd_chan_id(cc), .i_cmd_word(cw),
    .i_cmd_err(cerr), .o_rsp_valid(rv), .i_rsp_ready(rr), .o_rsp_type(rt), .o_rsp_code(rc),
    .o_rsp_reason(rn), .i_frm_valid(fv), .i_frm_dst(fdst), .i_mcf_en(mcf_en), .i_mcf_addr(mcf_addr),
    .o_frm_valid(fov), .o_frm_fwd(fof), .i_chan_cong(cong), .o_xoff_gen(xoff),
    .o_pause_honor(honor), .o_chan_init(cinit));

  smf_mc_model smf_mc_model_inst (
    .i_clk_sys(clk), .i_cmd_ready(cr), .i_rsp_valid(rv), .i_rsp_type(rt), .i_rsp_code(rc),
    .i_rsp_reason(rn), .o_cmd_valid(cv), .o_cmd_type(ct), .o_cmd_chan_id(cc), .o_cmd_word(cw),
    .o_cmd_err(cerr), .o_rsp_ready(rr));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] t, input logic [7:0] ch, input logic [31:0] w, input logic e);
    smf_mc_model_inst.xfer(t, ch, w, e, $urandom_range(3), got, rsp);
  endtask

  function automatic logic [40:0] exp_rsp(input logic [7:0] t, input logic [7:0] en);
    logic [15:0] c;
    logic [15:0] r;
    c = RSP_COMPLETED;
    r = RSN_NONE;
    if (t == CMD_SET_FC && en > FC_BOTH) begin
      c = RSP_FAILED;
      r = RSN_PARAM;
    end else if (t == CMD_SET_FC && !CAP_FC_INDEP && (en == FC_GEN || en == FC_HONOR)) begin
      c = RSP_FAILED;
      r = RSN_FC_INDEP;
    end else if (t < CMD_GMC_EN || t > CMD_GET_VER) begin
      c = RSP_UNSUPPORTED;
      r = RSN_UNKNOWN;
    end
    return {1'b1, t | RSP_FLAG, c, r};
  endfunction

  function automatic logic fwd_exp(input logic [47:0] d, input logic all);
    return !d[MAC_IG_BIT] || all || (mcf_en[0] && mcf_addr[47:0] == d) || (mcf_en[1] && mcf_addr[95:48] == d);
  endfunction

  // Back to back frames; each result is checked one edge after its launch
  task automatic frames(input logic all, input int cnt);
    logic [47:0] d, pd;
    int i;
    pd = 48'h0;
    for (i = 0; i <= cnt; i++) begin
      d = 48'({$urandom, $urandom});
      case ($urandom_range(3))
        1: d = mcf_addr[47:0];
        2: d = mcf_addr[95:48];
        3: d[MAC_IG_BIT] = 1'b1;
        default: ;
      endcase
      @(posedge clk);
      if (i == 0) mcf_en <= 2'($urandom);
      fv <= (i < cnt);
      fdst <= d;
      #1;
      if (i > 0) chk("frm_fwd", 41'({fov, fof}), 41'({1'b1, fwd_exp(pd, all)}));
      pd = d;
    end
  endtask

  task automatic cong_run(input logic two);
    hi = 0;
    ini = 0;
    @(posedge clk);
    cong <= 4'h1;
    repeat (80) begin
      @(posedge clk);
      if (hi + ini == 10 && two) cong <= 4'h3;
      #1;
      hi += int'(xoff);
      ini += $countones(cinit);
    end
    cong <= 4'h0;
    repeat (5) @(posedge clk);
  endtask

  initial begin
    #(25 * 20000);
    mismatches++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, fv} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fdst = 48'h0;
    cong = 4'h0;
    void'($urandom(20392));
    mcf_en = 2'b11;
    mcf_addr = {$urandom, $urandom, $urandom} | {8'h01, 40'h0, 8'h01, 40'h0};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", 41'(rd), 41'(32'h0));
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat_rst", 41'(rd), 41'(32'h0));
    apb(1'b0, REG_PKG, 32'h0);
    chk("pkg_rst", 41'(rd), 41'(32'h0));
    apb(1'b1, 12'h00C, $urandom);
    chk("unmapped_wr", 41'(er), 41'(1'b1));
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_rd", 41'({er, rd}), 41'({1'b1, 32'h0}));
    $display("test registers done");
    cmd(CMD_GMC_EN, 8'h00, $urandom, 1'b0);
    chk("rsp_gmc_en", {got, rsp}, exp_rsp(CMD_GMC_EN, 8'h00));
    frames(1'b0, 40);
    cmd(CMD_GMC_DIS, 8'h00, $urandom, 1'b0);
    chk("rsp_gmc_dis", {got, rsp}, exp_rsp(CMD_GMC_DIS, 8'h00));
    apb(1'b0, REG_CTRL, 32'h0);
    chk("mcall", 41'(rd[0]), 41'(1'b1));
    frames(1'b1, 40);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_wr", 41'(rd), 41'(32'h0));
    cmd(CMD_GET_VER, 8'h00, $urandom, 1'b0);
    chk("rsp_ver", {got, rsp}, exp_rsp(CMD_GET_VER, 8'h00));
    cmd(8'h7F, 8'h00, $urandom, 1'b0);
    chk("rsp_unknown", {got, rsp}, exp_rsp(8'h7F, 8'h00));
    $display("test multicast done");
    apb(1'b1, REG_PKG, 32'h5);
    tbl[6] = 8'($urandom_range(254, 5));
    for (int i = 0; i < 8; i++) begin
      cmd(CMD_SET_FC, {3'h5, CHAN_PKG}, {24'($urandom), tbl[i]}, 1'b0);
      chk("rsp_fc", {got, rsp}, exp_rsp(CMD_SET_FC, tbl[i]));
      if (tbl[i] == FC_OFF || tbl[i] == FC_BOTH) mode = tbl[i][1:0];
      apb(1'b0, REG_STAT, 32'h0);
      chk("fc_mode", 41'({honor, rd[1:0]}), 41'({mode[1], mode}));
    end
    cmd(CMD_SET_FC, {3'h0, CHAN_PKG}, 32'h0, 1'b0);
    chk("drop_pkg", 41'(got), 41'(1'b0));
    cmd(CMD_SET_FC, {3'h5, 5'h00}, 32'h0, 1'b0);
    chk("drop_chan", 41'(got), 41'(1'b0));
    cmd(CMD_SET_FC, {3'h5, CHAN_PKG}, 32'h0, 1'b1);
    chk("drop_err", 41'(got), 41'(1'b0));
    apb(1'b0, REG_STAT, 32'h0);
    chk("mode_kept", 41'(rd[1:0]), 41'(2'h3));
    $display("test flow control commands done");
    cong_run(1'b0);
    chk("xoff_one", 41'({hi >= LIM - 1 && hi <= LIM + 2, ini == 1}), 41'(2'b11));
    cong_run(1'b1);
    chk("xoff_two", 41'({hi >= LIM + 9 && hi <= LIM + 12, ini == 2}), 41'(2'b11));
    cmd(CMD_SET_FC, {3'h5, CHAN_PKG}, 32'h0, 1'b0);
    cong_run(1'b0);
    chk("xoff_off", 41'({hi == 0, ini == 0}), 41'(2'b11));
    $display("test congestion done");
    wrap_up();
  end
endmodule
